// ===== rtl/smx_engine.sv
/*
 * Command engine for the 48-bit set-maximum, its 28-bit set-maximum
 * subcommands and set-multiple, behind a classic Wishbone slave.
 * Assumes a single 40 MHz clock, synchronous reset, and that the media
 * path presents one access request per cycle on the media_* ports.
 */
`timescale 1ns/100ps

module smx_engine #(
    parameter logic [47:0] NATIVE_MAX = 48'h0000ffffffff,
    parameter int          MAX_BLOCK  = 16
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        power_cycle,
    input  wire logic        nv_erase,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        media_req,
    input  wire logic [47:0] media_lba,
    output logic             media_grant,
    output logic             media_abort,
    output logic             mult_enable,
    output logic      [7:0]  mult_size
);
    import smx_pkg::*;

    if (NATIVE_MAX == 48'h0) begin : g_bad_native
        $error("NATIVE_MAX must be nonzero");
    end

    smx_chk_if chk ();
    smx_judge #(.MAX_BLOCK(MAX_BLOCK)) u_judge (.chk(chk));

    smx_state_type state;
    logic [7:0]    opcode;
    logic [23:0]   task_word;
    logic [23:0]   lba_cur;
    logic [23:0]   lba_prev;
    logic [2:0]    ctrl;
    logic [7:0]    error_flags;
    logic [7:0]    status_flags;
    logic [47:0]   result;
    logic [47:0]   vol_max;
    logic          vol_valid;
    logic [47:0]   nv_max;
    logic          nv_valid;
    logic [47:0]   id100;
    logic [27:0]   id60;
    logic          prior_native;
    logic          hpa28;
    logic          locked;
    logic          frozen;
    logic          persist_used;
    logic [47:0]   req_lba;
    logic [47:0]   eff_max;
    logic [31:0]   wmask;
    logic          bus_req;
    logic          wr_cmd;
    logic          exec;
    logic          abort;
    logic          lost_power;
    logic [23:0]   hob_view;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode and shared terms
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr_cmd  = bus_req && wb_we_i && wb_sel_i[0]
                     && (wb_adr_i == OFF_CMD);
    assign exec    = (state == S_EXEC);
    assign lost_power = rst || power_cycle;

    // Register pairs: current bytes low, previous bytes high
    assign req_lba = {lba_prev, lba_cur};
    // Volatile limit wins, then the retained one, then true size
    assign eff_max = vol_valid ? vol_max : (nv_valid ? nv_max : NATIVE_MAX);
    // Read-back view: HOB picks the high three bytes
    assign hob_view = ctrl[CTRL_HOB] ? result[47:24] : result[23:0];

    assign chk.req_lba      = req_lba;
    assign chk.native_max   = NATIVE_MAX;
    assign chk.persist      = task_word[TASK_CNT_LSB];
    assign chk.supported    = ctrl[CTRL_SUPPORTED];
    assign chk.offset_mode  = ctrl[CTRL_OFFSET];
    assign chk.prior_native = prior_native;
    assign chk.hpa28        = hpa28;
    assign chk.locked       = locked;
    assign chk.frozen       = frozen;
    assign chk.persist_used = persist_used;
    assign chk.blk_size     = task_word[TASK_CNT_LSB +: 8];

    ////////////////////////////////////////////////////////////////////////
    // Verdict for the command under execution
    always_comb begin
        abort = 1'b1;
        unique case (opcode)
            OP_READ_NATIVE: abort = 1'b0;
            OP_SET_MAX_EXT: abort = chk.sm_abort;
            OP_SET_MULT:    abort = chk.blk_abort;
            OP_SET_MAX: begin
                if (frozen || !prior_native)
                    abort = 1'b1;
                else if (task_word[7:0] == FEAT_SET_ADDR)
                    abort = locked;
                else
                    abort = !(task_word[7:0] == FEAT_LOCK ||
                              task_word[7:0] == FEAT_UNLOCK ||
                              task_word[7:0] == FEAT_FREEZE);
            end
            default:        abort = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone answer: one wait state, unmapped reads return zero
    always_ff @(posedge clock) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req;
            unique case (wb_adr_i)
                OFF_TASK:     wb_dat_o <= {8'h0, task_word};
                OFF_LBA_CUR:  wb_dat_o <= {8'h0, lba_cur};
                OFF_LBA_PREV: wb_dat_o <= {8'h0, lba_prev};
                OFF_RESULT:   wb_dat_o <= {8'h0, hob_view};
                OFF_CTRL:     wb_dat_o <= {29'h0, ctrl};
                OFF_ERROR:    wb_dat_o <= {24'h0, error_flags};
                OFF_STATUS:   wb_dat_o <= {24'h0, status_flags};
                OFF_ID60:     wb_dat_o <= {4'h0, id60};
                OFF_ID100:    wb_dat_o <= id100[31:0];
                OFF_ID102:    wb_dat_o <= {16'h0, id100[47:32]};
                OFF_MULT:     wb_dat_o <= {23'h0, mult_enable, mult_size};
                default:      wb_dat_o <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host-written task words and control; writes during busy still land
    always_ff @(posedge clock) begin
        if (rst) begin
            task_word <= 24'h0;
            lba_cur   <= 24'h0;
            lba_prev  <= 24'h0;
            ctrl      <= CTRL_RESET;
        end else if (bus_req && wb_we_i) begin
            if (wb_adr_i == OFF_TASK)
                task_word <= (task_word & ~wmask[23:0])
                           | (wb_dat_i[23:0] & wmask[23:0]);
            if (wb_adr_i == OFF_LBA_CUR)
                lba_cur <= (lba_cur & ~wmask[23:0])
                         | (wb_dat_i[23:0] & wmask[23:0]);
            if (wb_adr_i == OFF_LBA_PREV)
                lba_prev <= (lba_prev & ~wmask[23:0])
                          | (wb_dat_i[23:0] & wmask[23:0]);
            if (wb_adr_i == OFF_CTRL && wb_sel_i[0])
                ctrl <= wb_dat_i[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer; a command written while busy is dropped
    always_ff @(posedge clock) begin
        if (rst) begin
            state  <= S_IDLE;
            opcode <= 8'h00;
        end else begin
            unique case (state)
                S_IDLE: if (wr_cmd) begin
                    opcode <= wb_dat_i[7:0];
                    state  <= S_EXEC;
                end
                S_EXEC: state <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Completion flags: busy while executing, abort raises both flags
    always_ff @(posedge clock) begin
        if (rst) begin
            status_flags <= STATUS_RESET;
            error_flags  <= ERROR_RESET;
        end else if (wr_cmd && state == S_IDLE) begin
            status_flags[ST_BSY] <= 1'b1;
        end else if (exec) begin
            status_flags <= STATUS_RESET;
            status_flags[ST_ERR] <= abort;
            error_flags  <= ERROR_RESET;
            error_flags[ERR_ABORT] <= abort;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Protection state; lost at power-on or hardware reset
    always_ff @(posedge clock) begin
        if (lost_power) begin
            prior_native <= 1'b0;
            hpa28        <= 1'b0;
            locked       <= 1'b0;
            frozen       <= 1'b0;
            persist_used <= 1'b0;
        end else if (exec) begin
            // Only a native read arms the next set-max
            prior_native <= (opcode == OP_READ_NATIVE);
            if (opcode == OP_SET_MAX_EXT && !abort
                && task_word[TASK_PERSIST])
                persist_used <= 1'b1;
            if (opcode == OP_SET_MAX && !abort) begin
                unique case (task_word[7:0])
                    FEAT_SET_ADDR: hpa28  <= 1'b1;
                    FEAT_LOCK:     locked <= 1'b1;
                    FEAT_UNLOCK:   locked <= 1'b0;
                    default:       frozen <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Volatile limit: dropped by power-on and hardware reset
    always_ff @(posedge clock) begin
        if (lost_power) begin
            vol_max   <= 48'h0;
            vol_valid <= 1'b0;
        end else if (exec && !abort) begin
            if (opcode == OP_SET_MAX_EXT) begin
                vol_max   <= req_lba;
                vol_valid <= !task_word[TASK_PERSIST];
            end else if (opcode == OP_SET_MAX
                         && task_word[7:0] == FEAT_SET_ADDR) begin
                vol_max   <= req_lba & LBA28_LIMIT;
                vol_valid <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Retained limit: survives power cycles, cleared only when reset is
    // held with nv_erase, standing in for a factory erase
    always_ff @(posedge clock) begin
        if (rst && nv_erase) begin
            nv_max   <= 48'h0;
            nv_valid <= 1'b0;
        end else if (!rst && exec && !abort
                     && opcode == OP_SET_MAX_EXT
                     && task_word[TASK_PERSIST]) begin
            nv_max   <= req_lba;
            nv_valid <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-back value and identify capacity words
    always_ff @(posedge clock) begin
        if (rst) begin
            result <= 48'h0;
            id100  <= NATIVE_MAX;
            id60   <= (NATIVE_MAX > LBA28_LIMIT) ? LBA28_LIMIT[27:0]
                                                 : NATIVE_MAX[27:0];
        end else if (exec && !abort) begin
            if (opcode == OP_READ_NATIVE)
                result <= NATIVE_MAX;
            if (opcode == OP_SET_MAX_EXT) begin
                result <= req_lba;
                id100  <= req_lba;
                if (req_lba <= LBA28_LIMIT)
                    id60 <= req_lba[27:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Multiple-sector mode; an invalid size turns it off too
    always_ff @(posedge clock) begin
        if (rst) begin
            mult_enable <= 1'b0;
            mult_size   <= 8'h00;
        end else if (exec && opcode == OP_SET_MULT) begin
            mult_enable <= chk.blk_enable;
            mult_size   <= chk.blk_abort ? 8'h00 : chk.blk_size;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Media gate: one cycle verdict against the live limit
    always_ff @(posedge clock) begin
        if (rst) begin
            media_grant <= 1'b0;
            media_abort <= 1'b0;
        end else begin
            media_grant <= media_req && (media_lba <= eff_max);
            media_abort <= media_req && (media_lba > eff_max);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_native_gate: assert property (
        exec && opcode == OP_SET_MAX_EXT && !prior_native
        |=> error_flags[ERR_ABORT] && status_flags[ST_ERR])
        else $error("set-max ext without native read not aborted");
    a_media_limit: assert property (
        media_req && media_lba > eff_max && !exec
        |=> media_abort && !media_grant)
        else $error("access beyond limit not aborted");
    a_id_high_only: assert property (
        exec && opcode == OP_SET_MAX_EXT && !abort
        && req_lba > LBA28_LIMIT
        |=> id100 == $past(req_lba) && $stable(id60))
        else $error("wrong identify update above 28-bit limit");
    a_id_both: assert property (
        exec && opcode == OP_SET_MAX_EXT && !abort
        && req_lba <= LBA28_LIMIT
        |=> id100 == $past(req_lba) && id60 == $past(req_lba[27:0]))
        else $error("wrong identify update within 28-bit limit");
    a_persist_once: assert property (
        exec && opcode == OP_SET_MAX_EXT && persist_used
        && task_word[TASK_PERSIST] |=> error_flags[ERR_ABORT])
        else $error("second persistent set-max accepted");
    a_offset_persist: assert property (
        exec && opcode == OP_SET_MAX_EXT && ctrl[CTRL_OFFSET]
        && task_word[TASK_PERSIST] |=> error_flags[ERR_ABORT])
        else $error("persistent set-max accepted in offset mode");
    a_frozen_reject: assert property (
        exec && frozen
        && (opcode == OP_SET_MAX || opcode == OP_SET_MAX_EXT)
        |=> error_flags[ERR_ABORT])
        else $error("set-max accepted while frozen");
    a_bad_block: assert property (
        exec && opcode == OP_SET_MULT && chk.blk_abort
        |=> !mult_enable && error_flags[ERR_ABORT])
        else $error("invalid block size not rejected");
    a_busy_window: assert property (
        wr_cmd && state == S_IDLE
        |=> status_flags[ST_BSY] ##1 !status_flags[ST_BSY]
            && status_flags[ST_ERR] == error_flags[ERR_ABORT])
        else $error("busy or error summary wrong at completion");

    c_set_max_ok: cover property (
        exec && opcode == OP_SET_MAX_EXT && !abort);
    c_mult_ok: cover property (
        exec && opcode == OP_SET_MULT && chk.blk_enable);
    c_media_abort: cover property (media_abort);

endmodule

// ===== rtl/smx_pkg.sv
/*
 * Constants for the set-maximum and block-size command block: register
 * offsets, command opcodes, status and error bit positions, reset values.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package smx_pkg;

    // Register byte offsets, one aligned 32-bit word each
    localparam logic [5:0] OFF_CMD      = 6'h00;
    localparam logic [5:0] OFF_TASK     = 6'h04;
    localparam logic [5:0] OFF_LBA_CUR  = 6'h08;
    localparam logic [5:0] OFF_LBA_PREV = 6'h0c;
    localparam logic [5:0] OFF_RESULT   = 6'h10;
    localparam logic [5:0] OFF_CTRL     = 6'h14;
    localparam logic [5:0] OFF_ERROR    = 6'h18;
    localparam logic [5:0] OFF_STATUS   = 6'h1c;
    localparam logic [5:0] OFF_ID60     = 6'h20;
    localparam logic [5:0] OFF_ID100    = 6'h24;
    localparam logic [5:0] OFF_ID102    = 6'h28;
    localparam logic [5:0] OFF_MULT     = 6'h2c;

    // Task word fields
    localparam int TASK_FEAT_LSB  = 0;
    localparam int TASK_CNT_LSB   = 8;
    localparam int TASK_PERSIST   = 8;

    // Opcodes and set-max subcommands
    localparam logic [7:0] OP_SET_MAX_EXT  = 8'h37;
    localparam logic [7:0] OP_READ_NATIVE  = 8'h27;
    localparam logic [7:0] OP_SET_MULT     = 8'hc6;
    localparam logic [7:0] OP_SET_MAX      = 8'hf9;
    localparam logic [7:0] FEAT_SET_ADDR   = 8'h00;
    localparam logic [7:0] FEAT_LOCK       = 8'h02;
    localparam logic [7:0] FEAT_UNLOCK     = 8'h03;
    localparam logic [7:0] FEAT_FREEZE     = 8'h04;

    // Largest address that still fits the 28-bit identify words
    localparam logic [47:0] LBA28_LIMIT = 48'h00000fffffff;

    // Error and status bit positions
    localparam int ERR_ABORT = 2;
    localparam int ST_BSY    = 7;
    localparam int ST_RDY    = 6;
    localparam int ST_DSC    = 4;
    localparam int ST_ERR    = 0;

    // Control word bits
    localparam int CTRL_HOB       = 0;
    localparam int CTRL_OFFSET    = 1;
    localparam int CTRL_SUPPORTED = 2;

    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h50;
    localparam logic [7:0] ERROR_RESET  = 8'h00;
    localparam logic [2:0] CTRL_RESET   = 3'h4;

    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_EXEC = 2'b10
    } smx_state_type;

endpackage

// ===== rtl/smx_chk_if.sv
/*
 * Carrier between the command engine and its checker: the request under
 * test, the device state it depends on, and the verdicts.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/100ps
interface smx_chk_if;
    logic [47:0] req_lba;
    logic [47:0] native_max;
    logic        persist;
    logic        supported;
    logic        offset_mode;
    logic        prior_native;
    logic        hpa28;
    logic        locked;
    logic        frozen;
    logic        persist_used;
    logic [7:0]  blk_size;
    logic        sm_abort;
    logic        blk_abort;
    logic        blk_enable;

    modport judge (
        input  req_lba, native_max, persist, supported, offset_mode,
        input  prior_native, hpa28, locked, frozen, persist_used, blk_size,
        output sm_abort, blk_abort, blk_enable
    );
    modport user (
        output req_lba, native_max, persist, supported, offset_mode,
        output prior_native, hpa28, locked, frozen, persist_used, blk_size,
        input  sm_abort, blk_abort, blk_enable
    );
endinterface

// ===== rtl/smx_judge.sv
/*
 * Combinational verdicts for the 48-bit set-maximum request and for the
 * block size of the multiple-sector commands.
 * Assumes the engine holds every input stable while it samples verdicts.
 */
`timescale 1ns/100ps
module smx_judge #(
    parameter int MAX_BLOCK = 16
) (
    smx_chk_if.judge chk
);
    import smx_pkg::*;

    // Block size must be a power of two that the transfer logic can hold
    if (MAX_BLOCK < 1 || MAX_BLOCK > 128 ||
        (MAX_BLOCK & (MAX_BLOCK - 1)) != 0) begin : g_bad
        $error("MAX_BLOCK must be a power of two from 1 to 128");
    end

    logic size_ok;

    ////////////////////////////////////////////////////////////////////////
    // Every abort cause of the 48-bit set-maximum; any one is enough
    assign chk.sm_abort = !chk.supported
                        || (chk.req_lba > chk.native_max)
                        || chk.hpa28 || chk.locked
                        || chk.frozen
                        || !chk.prior_native
                        || (chk.persist && chk.persist_used)
                        || (chk.persist && chk.offset_mode);

    ////////////////////////////////////////////////////////////////////////
    // Zero is legal but switches the multiple commands off
    always_comb begin
        size_ok = (chk.blk_size == 8'h00);
        for (int i = 0; (1 << i) <= MAX_BLOCK; i++) begin
            if (chk.blk_size == 8'((1 << i)))
                size_ok = 1'b1;
        end
    end

    assign chk.blk_abort  = !size_ok;
    assign chk.blk_enable = size_ok && (chk.blk_size != 8'h00);

endmodule

// ===== sim/smx_host.sv
/*
 * Host controller model: a classic Wishbone master for the command block.
 * Assumes it shares the engine clock and is driven by the bench's tasks.
 */
`timescale 1ns/100ps
module smx_host (
    input  wire logic        clock,
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic      [5:0]  adr,
    output logic      [3:0]  sel,
    output logic      [31:0] dat,
    input  wire logic        ack,
    input  wire logic [31:0] rdat
);
    import smx_pkg::*;
    initial begin
        {cyc, stb, we, adr, sel, dat} = '0;
    end
    // One cycle, held until ack; data inverted on release so stale looks bad
    task automatic xfer(input logic w, input logic [5:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat <= d;
        do @(posedge clock); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        dat <= ~d;
    endtask
    // Address spread over current and previous register pairs
    task automatic put_lba(input logic [47:0] v);
        logic [31:0] q;
        xfer(1'b1, OFF_LBA_CUR, {8'h00, v[23:0]}, q);
        xfer(1'b1, OFF_LBA_PREV, {8'h00, v[47:24]}, q);
    endtask
endmodule

// ===== sim/max_address_and_block_size_cmds_tb.sv
/*
 * Self-checking bench for the set-maximum and block-size engine.
 * Assumes the engine acks one cycle after taking a request.
 */
`timescale 1ns/100ps
module max_address_and_block_size_cmds_tb;
    import smx_pkg::*;
    localparam logic [47:0] NMAX = 48'h0000ffffffff;
    logic clock = 0, rst = 1, power_cycle = 0, nv_erase = 1, media_req = 0;
    logic [47:0] media_lba = '0, lim;
    logic cyc, stb, we, ack, grant, mabort, men;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q, seed = 32'h47;
    logic [7:0] msize, esz;
    int error_cnt = 0, compares = 0, sizes[$] = '{0, 1, 2, 4, 8, 16, 3, 32};
    initial forever #12.5 clock = ~clock;
    smx_engine #(.NATIVE_MAX(NMAX), .MAX_BLOCK(16)) dut_u (.clock(clock),
        .rst(rst), .power_cycle(power_cycle), .nv_erase(nv_erase),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .media_req(media_req), .media_lba(media_lba), .media_grant(grant),
        .media_abort(mabort), .mult_enable(men), .mult_size(msize));
    smx_host host_u (.clock(clock), .cyc(cyc), .stb(stb), .we(we),
        .adr(adr), .sel(sel), .dat(wdat), .ack(ack), .rdat(rdat));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string n, input logic [47:0] e, g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // One-bit pin results, kept apart from register words
    task automatic chk_pin(input string n, input logic e, g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic rd(input string n, input logic [5:0] a, input [47:0] e);
        host_u.xfer(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, q);
    endtask
    // Command, then error and status as seen at completion
    task automatic cmd(input logic [7:0] op, input logic ab);
        wr(OFF_CMD, {24'h0, op});
        rd("error", OFF_ERROR, {5'h0, ab, 2'h0});
        rd("status", OFF_STATUS, {7'h28, ab});
    endtask
    // Native read right before set-max; model limit follows acceptance
    task automatic setmax(input logic [47:0] v, input logic b, ab);
        host_u.put_lba(v);
        wr(OFF_TASK, {23'h0, b, 8'h00});
        cmd(8'h27, 1'b0);
        cmd(8'h37, ab);
        if (!ab) lim = v;
    endtask
    task automatic media(input logic [47:0] a);
        @(posedge clock);
        media_req <= 1'b1;
        media_lba <= a;
        @(posedge clock);
        media_req <= 1'b0;
        #1;
        chk_pin("grant", a <= lim, grant);
        chk_pin("abort", a > lim, mabort);
    endtask
    task automatic pulse(input logic hard);
        @(posedge clock);
        {rst, nv_erase, power_cycle} <= {hard, hard, !hard};
        @(posedge clock);
        {rst, nv_erase, power_cycle} <= 3'b000;
    endtask
    task automatic summarize();
        $display("error_cnt %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clock);
        {rst, nv_erase} <= 2'b00;
        lim = NMAX;
        rd("status", OFF_STATUS, 48'h50);
        rd("error", OFF_ERROR, 48'h0);
        rd("ctrl", OFF_CTRL, 48'h4);
        host_u.put_lba(48'h1000);
        cmd(8'h37, 1'b1);
        setmax(48'h000012345678, 1'b0, 1'b0);
        rd("id60", OFF_ID60, 48'h0fffffff);
        rd("id100", OFF_ID100, 48'h12345678);
        rd("id102", OFF_ID102, 48'h0);
        rd("res_lo", OFF_RESULT, 48'h345678);
        wr(OFF_CTRL, 32'h5);
        rd("res_hi", OFF_RESULT, 48'h000012);
        media(lim);
        media(lim + 1);
        repeat (4) media({16'h0, rnd()});
        setmax(48'h000001000000, 1'b0, 1'b0);
        rd("id60", OFF_ID60, 48'h01000000);
        setmax(NMAX + 1, 1'b0, 1'b1);
        wr(OFF_CTRL, 32'h0);
        setmax(48'h100, 1'b0, 1'b1);
        wr(OFF_CTRL, 32'h4);
        pulse(1'b0);
        lim = NMAX;
        media(48'h01000001);
        setmax(48'h000080000000, 1'b1, 1'b0);
        setmax(48'h000090000000, 1'b1, 1'b1);
        pulse(1'b0);
        media(lim + 1);
        pulse(1'b1);
        lim = NMAX;
        wr(OFF_CTRL, 32'h6);
        setmax(48'h2000, 1'b1, 1'b1);
        wr(OFF_CTRL, 32'h4);
        // Locked state refuses the 48-bit set-max; after unlock, frozen state refuses it too
        cmd(8'h27, 1'b0);
        wr(OFF_TASK, 32'h02);
        cmd(8'hf9, 1'b0);
        setmax(48'h3000, 1'b0, 1'b1);
        cmd(8'h27, 1'b0);
        wr(OFF_TASK, 32'h03);
        cmd(8'hf9, 1'b0);
        cmd(8'h27, 1'b0);
        wr(OFF_TASK, 32'h04);
        cmd(8'hf9, 1'b0);
        setmax(48'h3000, 1'b0, 1'b1);
        // Power cycle thaws; a 28-bit area then blocks the 48-bit set-max
        pulse(1'b0);
        cmd(8'h27, 1'b0);
        wr(OFF_TASK, 32'h00);
        cmd(8'hf9, 1'b0);
        lim = 48'h3000;
        setmax(48'h2000, 1'b0, 1'b1);
        media(48'h3001);
        foreach (sizes[i]) begin
            wr(OFF_TASK, {16'h0, sizes[i][7:0], 8'h00});
            cmd(8'hc6, !(sizes[i] inside {0, 1, 2, 4, 8, 16}));
            esz = (sizes[i] inside {1, 2, 4, 8, 16}) ? 8'(sizes[i]) : 8'h00;
            rd("mult", OFF_MULT, {esz != 0, esz});
            chk("mult_size", esz, msize);
            chk_pin("mult_en", esz != 0, men);
        end
        summarize();
    end
endmodule
